// ==== core/pmwd_core.sv ====
// System watchdog of the power manager: kick sources, period and warning, timeout shutdown, retries.
// Assumes a registered host register port on clk_in, tick pulses and the kick pin from other domains,
// and a sequencer that reports the active state on seq_active_in in this clock domain.
`timescale 1ns/10ps
`default_nettype none
module pmwd_core
  import pmwd_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic kick_input_in,
  input wire logic kick_input_sel_in,
  input wire logic kick_input_level_mode_in,
  input wire logic otp_stop_bypass_in,
  input wire logic xtal_clk_ok_in,
  input wire logic xtal_tick_in,
  input wire logic slow_tick_in,
  input wire logic seq_active_in,
  input wire logic general_output_reset_sel_in,
  output logic irq_out,
  output logic armed_out,
  output logic shutdown_req_out,
  output logic main_reset_output_out,
  output logic secondary_reset_out,
  output logic standby_off_hold_out,
  output logic xtal_source_out
);

  // ----------------------------------------------------------------------------
  // Synchronisers for pin and foreign-clock inputs
  // ----------------------------------------------------------------------------
  localparam int SYNC_N = 4;
  logic [SYNC_N-1:0] meta_r;
  logic [SYNC_N-1:0] sync_r;
  logic [SYNC_N-1:0] sync_d_r;
  logic [SYNC_N-1:0] sync_nxt;

  always_comb begin
    sync_nxt = {slow_tick_in, xtal_tick_in, xtal_clk_ok_in, kick_input_in};
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      sync_r <= '0;
      sync_d_r <= '0;
    end else begin
      meta_r <= sync_nxt;
      sync_r <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  logic kick_level;
  logic kick_rise;
  logic xtal_ok;
  logic xtal_rise;
  logic slow_rise;
  logic tick;

  always_comb begin
    kick_level = sync_r[0];
    kick_rise = sync_r[0] & ~sync_d_r[0];
    xtal_ok = sync_r[1];
    xtal_rise = sync_r[2] & ~sync_d_r[2];
    slow_rise = sync_r[3] & ~sync_d_r[3];
    // A lost crystal falls back to the slow clock at once; the period stretches by their ratio.
    tick = xtal_ok ? xtal_rise : slow_rise;
  end

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  pmwd_req_t req;
  pmwd_state_t state_r;
  pmwd_state_t state_nxt;
  pmwd_tmr_t tmr;
  logic [DATA_W-1:0] fault_r;
  logic [DATA_W-1:0] fault_nxt;
  logic [DATA_W-1:0] event_r;
  logic [DATA_W-1:0] event_nxt;
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] mask_nxt;
  logic [RETRY_W-1:0] retry_field_r;
  logic [RETRY_W-1:0] retry_field_nxt;
  logic [RETRY_W-1:0] retry_r;
  logic [RETRY_W-1:0] retry_nxt;
  logic [PERIOD_SEL_W-1:0] period_sel_r;
  logic [PERIOD_SEL_W-1:0] period_sel_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic wd_enable;
  logic reg_kick;
  logic pin_kick;
  logic level_hold;
  logic kick_ok;
  logic timeout;
  logic restart;

  function automatic logic hit(input pmwd_req_t r, input logic [ADDR_W-1:0] a);
    return r.wr && (r.addr == a);
  endfunction

  always_comb begin
    req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
  end

  // ----------------------------------------------------------------------------
  // Kicks
  // ----------------------------------------------------------------------------
  always_comb begin
    wd_enable = (period_sel_r != PERIOD_SEL_OFF);
    reg_kick = hit(req, ADDR_CONTROL_F) && req.wdata[KICK_BIT];
    pin_kick = kick_input_sel_in && kick_rise;
    level_hold = kick_input_sel_in && kick_input_level_mode_in && kick_level;
    // Outside level mode a kick that comes too early is ignored rather than accepted.
    kick_ok = level_hold || ((reg_kick || pin_kick) && (kick_input_level_mode_in || tmr.min_ok));
    timeout = (state_r == PMWD_ARMED) && tmr.full;
    restart = kick_ok || (state_r != PMWD_ARMED);
  end

  pmwd_timer u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .run_in(state_r == PMWD_ARMED),
    .restart_in(restart),
    .tick_in(tick),
    .period_in(pmwd_period(period_sel_r)),
    .tmr_out(tmr)
  );

  // ----------------------------------------------------------------------------
  // Registers and control
  // ----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    fault_nxt = fault_r;
    event_nxt = event_r;
    mask_nxt = mask_r;
    retry_field_nxt = retry_field_r;
    retry_nxt = retry_r;
    period_sel_nxt = period_sel_r;
    rdata_nxt = rdata_r;

    // Write-one-to-clear first, so a hardware set in the same cycle wins.
    if (hit(req, ADDR_FAULT_RECORD)) begin
      fault_nxt[TIMEOUT_FAULT_BIT] = fault_r[TIMEOUT_FAULT_BIT] & ~req.wdata[TIMEOUT_FAULT_BIT];
    end
    if (hit(req, ADDR_EVENT_GROUP_A)) begin
      event_nxt[WARNING_EVENT_BIT] = event_r[WARNING_EVENT_BIT] & ~req.wdata[WARNING_EVENT_BIT];
    end
    if (hit(req, ADDR_IRQ_MASK_GROUP_A)) begin
      mask_nxt = REG_ZERO;
      mask_nxt[WARNING_MASK_BIT] = req.wdata[WARNING_MASK_BIT];
    end
    if (hit(req, ADDR_CONTROL_B)) begin
      retry_field_nxt = req.wdata[RETRY_LSB +: RETRY_W];
      retry_nxt = req.wdata[RETRY_LSB +: RETRY_W];
    end
    if (hit(req, ADDR_CONTROL_D)) begin
      // Switching off is refused once armed; only the one-time bypass lets it through.
      if ((req.wdata[PERIOD_SEL_W-1:0] != PERIOD_SEL_OFF) || (state_r != PMWD_ARMED) || otp_stop_bypass_in) begin
        period_sel_nxt = req.wdata[PERIOD_SEL_W-1:0];
      end
    end

    if ((state_r == PMWD_ARMED) && tmr.half) begin
      event_nxt[WARNING_EVENT_BIT] = 1'b1;
    end

    unique case (state_r)
      PMWD_IDLE: begin
        if (wd_enable && seq_active_in) begin
          state_nxt = PMWD_ARMED;
        end
      end
      PMWD_ARMED: begin
        if (!wd_enable) begin
          state_nxt = PMWD_IDLE;
        end else if (timeout) begin
          fault_nxt[TIMEOUT_FAULT_BIT] = 1'b1;
          state_nxt = PMWD_SHUT;
          if (retry_r != '0) begin
            retry_nxt = retry_r - 2'h1;
          end
        end
      end
      PMWD_SHUT: begin
        if (!seq_active_in) begin
          state_nxt = (retry_r == '0) ? PMWD_FROZEN : PMWD_IDLE;
        end
      end
      PMWD_FROZEN: begin
        state_nxt = PMWD_FROZEN;
      end
    endcase

    if (req.rd) begin
      unique case (req.addr)
        ADDR_FAULT_RECORD: rdata_nxt = fault_r;
        ADDR_EVENT_GROUP_A: rdata_nxt = event_r;
        ADDR_IRQ_MASK_GROUP_A: rdata_nxt = mask_r;
        ADDR_CONTROL_B: begin
          rdata_nxt = REG_ZERO;
          rdata_nxt[RETRY_LSB +: RETRY_W] = retry_field_r;
        end
        ADDR_CONTROL_D: rdata_nxt = DATA_W'(period_sel_r);
        default: rdata_nxt = REG_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= PMWD_IDLE;
      fault_r <= REG_ZERO;
      event_r <= REG_ZERO;
      mask_r <= MASK_A_RST;
      retry_field_r <= RETRY_RST;
      retry_r <= RETRY_RST;
      period_sel_r <= PERIOD_SEL_OFF;
      rdata_r <= REG_ZERO;
      irq_out <= 1'b0;
      armed_out <= 1'b0;
      shutdown_req_out <= 1'b0;
      main_reset_output_out <= 1'b0;
      secondary_reset_out <= 1'b0;
      standby_off_hold_out <= 1'b0;
      xtal_source_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fault_r <= fault_nxt;
      event_r <= event_nxt;
      mask_r <= mask_nxt;
      retry_field_r <= retry_field_nxt;
      retry_r <= retry_nxt;
      period_sel_r <= period_sel_nxt;
      rdata_r <= rdata_nxt;
      irq_out <= event_nxt[WARNING_EVENT_BIT] & ~mask_nxt[WARNING_MASK_BIT];
      armed_out <= (state_nxt == PMWD_ARMED);
      shutdown_req_out <= timeout && wd_enable;
      main_reset_output_out <= (state_nxt == PMWD_SHUT);
      secondary_reset_out <= (state_nxt == PMWD_SHUT) && general_output_reset_sel_in;
      standby_off_hold_out <= (state_nxt == PMWD_FROZEN);
      xtal_source_out <= xtal_ok;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  chk_timeout_logs_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (timeout && wd_enable) |=> fault_r[TIMEOUT_FAULT_BIT] && (state_r == PMWD_SHUT) && shutdown_req_out)
    else $error("timeout did not log a fault and shut down");

  chk_no_stop_locked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((state_r == PMWD_ARMED) && !otp_stop_bypass_in) |=> (period_sel_r != PERIOD_SEL_OFF))
    else $error("armed watchdog was switched off without bypass");

  chk_tick_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!xtal_ok && !slow_rise) || (xtal_ok && !xtal_rise) |-> !tick)
    else $error("tick taken from the wrong clock source");

  chk_arm_on_active: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((state_r == PMWD_IDLE) && wd_enable && seq_active_in) |=> (state_r == PMWD_ARMED) && armed_out)
    else $error("watchdog did not arm on entry to active");

  chk_warn_recorded: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((state_r == PMWD_ARMED) && tmr.half) |=> event_r[WARNING_EVENT_BIT])
    else $error("half period passed without warning event");

  chk_level_hold_safe: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((state_r == PMWD_ARMED) && wd_enable && level_hold) [*2] |=> (state_r == PMWD_ARMED))
    else $error("held kick input did not prevent timeout");

  chk_secondary_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((state_r == PMWD_SHUT) && $past(general_output_reset_sel_in)) |-> secondary_reset_out && main_reset_output_out)
    else $error("secondary reset missing during watchdog power-down");

  chk_retry_decrement: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (timeout && wd_enable && (retry_r != '0) && !hit(req, ADDR_CONTROL_B)) |=> (retry_r == $past(retry_r) - 2'h1))
    else $error("retry counter not decremented on timeout");

  chk_frozen_stays: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == PMWD_FROZEN) |=> (state_r == PMWD_FROZEN) && standby_off_hold_out)
    else $error("device left standby-off after retries ran out");

  chk_mask_blocks_irq: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mask_r[WARNING_MASK_BIT] |-> !irq_out)
    else $error("masked warning produced an interrupt");

endmodule // pmwd_core
`default_nettype wire

// ==== core/pmwd_pkg.sv ====
// Package for the system watchdog: register map, field layout, reset values, states and timing.
// Assumes an 8-bit register port with a 9-bit address and a watchdog tick near 32 kHz.
package pmwd_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_RECORD = 9'h005;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_GROUP_A = 9'h006;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK_GROUP_A = 9'h00a;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = 9'h00f;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_D = 9'h011;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_F = 9'h013;

  // ----------------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------------
  localparam int TIMEOUT_FAULT_BIT = 0;
  localparam int WARNING_EVENT_BIT = 3;
  localparam int WARNING_MASK_BIT = 3;
  localparam int KICK_BIT = 0;
  localparam int RETRY_LSB = 5;
  localparam int RETRY_W = 2;
  localparam int PERIOD_SEL_W = 3;
  localparam logic [DATA_W-1:0] REG_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] MASK_A_RST = 8'h00;
  localparam logic [RETRY_W-1:0] RETRY_RST = 2'h3;
  localparam logic [PERIOD_SEL_W-1:0] PERIOD_SEL_OFF = 3'h0;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CNT_W = 23;
  localparam int TICK_HZ = 32768;
  localparam logic [CNT_W-1:0] BASE_PERIOD_TICKS = 23'h008000;
  localparam int MIN_KICK_US = 1000;
  localparam logic [CNT_W-1:0] MIN_KICK_TICKS = CNT_W'((MIN_KICK_US * TICK_HZ + 999999) / 1000000);

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMWD_IDLE = 2'b00,
    PMWD_ARMED = 2'b01,
    PMWD_SHUT = 2'b11,
    PMWD_FROZEN = 2'b10
  } pmwd_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pmwd_req_t;

  typedef struct packed {
    logic half;
    logic full;
    logic min_ok;
  } pmwd_tmr_t;

  // Period in watchdog ticks; select 1 gives the base period, each step doubles it.
  function automatic logic [CNT_W-1:0] pmwd_period(input logic [PERIOD_SEL_W-1:0] sel);
    logic [CNT_W-1:0] p;
    p = BASE_PERIOD_TICKS << (sel - 3'h1);
    return p;
  endfunction

endpackage

// ==== core/pmwd_timer.sv ====
// Period counter of the system watchdog, counting slow watchdog ticks.
// Assumes tick_in is a one-cycle pulse on clk_in and restart_in comes from the same domain.
`timescale 1ns/10ps
`default_nettype none
module pmwd_timer
  import pmwd_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic tick_in,
  input wire logic [CNT_W-1:0] period_in,
  output pmwd_tmr_t tmr_out
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  pmwd_tmr_t tmr_r;
  pmwd_tmr_t tmr_nxt;

  // ----------------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    tmr_nxt = '0;
    if (!run_in || restart_in) begin
      cnt_nxt = '0;
    end else if (tick_in) begin
      cnt_nxt = cnt_r + 23'h000001;
      tmr_nxt.half = (cnt_nxt == (period_in >> 1));
      if (cnt_nxt >= period_in) begin
        tmr_nxt.full = 1'b1;
        cnt_nxt = '0;
      end
    end
    tmr_nxt.min_ok = (cnt_nxt >= MIN_KICK_TICKS);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
      tmr_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign tmr_out = tmr_r;

  chk_restart_clears_count: assert property (@(posedge clk_in) disable iff (!nrst_in)
    restart_in |=> (cnt_r == '0) && !tmr_r.full && !tmr_r.half)
    else $error("restart did not clear the watchdog count");

endmodule // pmwd_timer
`default_nettype wire

// ==== verification/pmwd_host_model.sv ====
// Host-side model of the kick pin: a short kick pulse on request, or a level held high.
// Assumes the bench raises its requests on the clk_in edge, one cycle per pulse request.
`timescale 1ns/10ps
`default_nettype none
module pmwd_host_model (
  input wire logic clk_in,
  input wire logic pulse_req_in,
  input wire logic hold_req_in,
  output logic kick_input_out
);
  logic [2:0] pulse_cnt_r = 3'h0;

  // A pulse lasts four cycles so that the two-stage synchroniser cannot miss it.
  always_ff @(posedge clk_in) begin
    if (pulse_req_in) begin
      pulse_cnt_r <= 3'h4;
    end else if (pulse_cnt_r != 3'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 3'h1;
    end
  end

  // The pin idles low; a held request keeps it high for as long as the bench wants.
  assign kick_input_out = hold_req_in || (pulse_cnt_r != 3'h0);
endmodule // pmwd_host_model
`default_nettype wire

// ==== verification/pmic_system_watchdog_tb.sv ====
// Self-checking bench for the watchdog core: arming, both kick sources, warning, mask, stop lock, timeout.
// Assumes one fast tick source feeds both tick inputs, one tick every two system cycles.
`timescale 1ns/10ps
`default_nettype none
module pmic_system_watchdog_tb
  import pmwd_pkg::*;
;
  localparam int HALF_T = 16384;
  localparam int FULL_T = 32768;
  localparam int KICK_T = 100;
  localparam int REL_T = 17000;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic pulse_req = 1'b0;
  logic hold_req = 1'b0;
  logic level_mode = 1'b0;
  logic xtal_ok = 1'b0;
  logic tick = 1'b0;
  logic tick_run = 1'b0;
  logic seq_active = 1'b0;
  logic bypass = 1'b0;
  logic gor_sel = 1'b1;
  logic kick_pin, irq, armed, shut_req, main_rst, sec_rst, hold, xsrc;
  int tick_cnt = 0;
  int num_errors = 0;
  int compares = 0;

  // ----------------------------------------------------------------------------
  // Clock, ticks and instances
  // ----------------------------------------------------------------------------
  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (tick_run) begin
      tick <= ~tick;
      if (!tick) tick_cnt <= tick_cnt + 1;
    end
  end

  pmwd_host_model i_host (.clk_in(clk_in), .pulse_req_in(pulse_req), .hold_req_in(hold_req),
                          .kick_input_out(kick_pin));

  pmwd_core i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .kick_input_in(kick_pin),
    .kick_input_sel_in(1'b1), .kick_input_level_mode_in(level_mode), .otp_stop_bypass_in(bypass),
    .xtal_clk_ok_in(xtal_ok), .xtal_tick_in(tick), .slow_tick_in(tick), .seq_active_in(seq_active),
    .general_output_reset_sel_in(gor_sel), .irq_out(irq), .armed_out(armed), .shutdown_req_out(shut_req),
    .main_reset_output_out(main_rst), .secondary_reset_out(sec_rst), .standby_off_hold_out(hold),
    .xtal_source_out(xsrc));

  // ----------------------------------------------------------------------------
  // Bus cycles, waits and comparisons
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic check_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] m, input string what);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 check_reg(rdata & m, exp, what);
  endtask

  task automatic wait_tick(input int n);
    while (tick_cnt < n) @(posedge clk_in);
    #1;
  endtask

  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_reset_values();
    expect_reg(ADDR_FAULT_RECORD, 8'h00, 8'hff, "fault record after reset");
    expect_reg(ADDR_EVENT_GROUP_A, 8'h00, 8'hff, "events after reset");
    expect_reg(ADDR_IRQ_MASK_GROUP_A, MASK_A_RST, 8'hff, "mask after reset");
    expect_reg(ADDR_CONTROL_B, 8'h60, 8'h60, "retry count after reset");
    expect_reg(9'h0ff, 8'h00, 8'hff, "unmapped read");
    check_pin(xsrc, 1'b0, "internal tick without crystal");
    @(posedge clk_in);
    xtal_ok <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1 check_pin(xsrc, 1'b1, "crystal tick once good");
  endtask

  task automatic test_arming();
    wr(ADDR_CONTROL_B, 8'h20);
    expect_reg(ADDR_CONTROL_B, 8'h20, 8'h60, "retry count written");
    wr(ADDR_CONTROL_D, 8'h01);
    repeat (5) @(posedge clk_in);
    #1 check_pin(armed, 1'b0, "armed before active");
    @(posedge clk_in);
    seq_active <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check_pin(armed, 1'b1, "armed on entry to active");
    // The bypass stays up until the core has left the armed state, so the lock check never sees a stop.
    @(posedge clk_in);
    bypass <= 1'b1;
    wr(ADDR_CONTROL_D, 8'h00);
    repeat (3) @(posedge clk_in);
    #1 check_pin(armed, 1'b0, "stopped through the one-time bypass");
    @(posedge clk_in);
    bypass <= 1'b0;
    wr(ADDR_CONTROL_D, 8'h01);
    repeat (3) @(posedge clk_in);
    #1 check_pin(armed, 1'b1, "armed again after bypass stop");
    @(posedge clk_in);
    tick_run <= 1'b1;
  endtask

  // The register kick restarts the count; the pin pulse 20 ticks later is too soon and must be dropped.
  task automatic test_kick_warning();
    wait_tick(KICK_T);
    wr(ADDR_CONTROL_F, 8'h01);
    wait_tick(KICK_T + 20);
    @(posedge clk_in);
    pulse_req <= 1'b1;
    @(posedge clk_in);
    pulse_req <= 1'b0;
    wait_tick(KICK_T + HALF_T - 4);
    expect_reg(ADDR_EVENT_GROUP_A, 8'h00, 8'h08, "warning before restarted half");
    wait_tick(KICK_T + HALF_T + 6);
    expect_reg(ADDR_EVENT_GROUP_A, 8'h08, 8'h08, "warning at half period");
    check_pin(irq, 1'b1, "unmasked warning interrupt");
  endtask

  task automatic test_level_mask_lock();
    wr(ADDR_EVENT_GROUP_A, 8'h08);
    wr(ADDR_IRQ_MASK_GROUP_A, 8'h08);
    expect_reg(ADDR_EVENT_GROUP_A, 8'h00, 8'hff, "warning cleared");
    expect_reg(ADDR_IRQ_MASK_GROUP_A, 8'h08, 8'hff, "mask written");
    wr(ADDR_CONTROL_D, 8'h00);
    expect_reg(ADDR_CONTROL_D, 8'h01, 8'h07, "period kept after stop attempt");
    check_pin(armed, 1'b1, "still armed after stop attempt");
    @(posedge clk_in);
    level_mode <= 1'b1;
    hold_req <= 1'b1;
    wait_tick(REL_T);
    @(posedge clk_in);
    hold_req <= 1'b0;
    wait_tick(REL_T + HALF_T - 6);
    expect_reg(ADDR_EVENT_GROUP_A, 8'h00, 8'h08, "no warning while pin was held");
    wait_tick(REL_T + HALF_T + 6);
    expect_reg(ADDR_EVENT_GROUP_A, 8'h08, 8'h08, "masked warning recorded");
    check_pin(irq, 1'b0, "masked warning interrupt");
    wr(ADDR_IRQ_MASK_GROUP_A, 8'h00);
    repeat (2) @(posedge clk_in);
    #1 check_pin(irq, 1'b1, "interrupt after unmask");
  endtask

  task automatic test_timeout();
    wait_tick(REL_T + FULL_T - 6);
    expect_reg(ADDR_FAULT_RECORD, 8'h00, 8'h01, "fault before full period");
    check_pin(main_rst, 1'b0, "reset before full period");
    for (int i = 0; i < 40 && shut_req !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    check_pin(shut_req, 1'b1, "shutdown request at timeout");
    check_pin(main_rst, 1'b1, "main reset at timeout");
    check_pin(sec_rst, 1'b1, "secondary reset at timeout");
    @(posedge clk_in);
    #1 check_pin(shut_req, 1'b0, "shutdown request is one pulse");
    expect_reg(ADDR_FAULT_RECORD, 8'h01, 8'h01, "timeout fault logged");
    @(posedge clk_in);
    gor_sel <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 check_pin(sec_rst, 1'b0, "no secondary reset without assigned output");
    check_pin(main_rst, 1'b1, "main reset held while sequencer active");
    @(posedge clk_in);
    seq_active <= 1'b0;
    xtal_ok <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 check_pin(hold, 1'b1, "held in standby-off with no retries");
    check_pin(main_rst, 1'b0, "main reset released after power-down");
    check_pin(xsrc, 1'b0, "internal tick after crystal loss");
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    test_reset_values();
    test_arming();
    test_kick_warning();
    test_level_mask_lock();
    test_timeout();
    results();
  end

  // The whole run needs about 100,000 cycles, nearly all of it waiting out about one and a half watchdog periods.
  initial begin
    #(110000 * 20);
    num_errors++;
    results();
  end
endmodule // pmic_system_watchdog_tb
`default_nettype wire
